// ===== testbench/lpm_bank_properties.sv
// port checker for the led port mask and test register bank
`timescale 1ns/1ns
module lpm_bank_chk (
    input wire logic             mclk_i,
    input wire logic             reset_n_i,
    input wire logic             scl_i,
    input wire logic             sda_oe_o,
    input wire logic [6:0]       port_in_i,
    input wire logic [27:0]      seg_on_i,
    input wire logic [27:0][4:0] drive_level_increment_o,
    input wire logic             test_mode_o,
    input wire logic             change_flag_o
);
    logic over_range;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // any segment above full scale
    always_comb begin
        over_range = 1'b0;
        for (int k = 0; k < 28; k++) begin
            over_range |= drive_level_increment_o[k] > 5'h10;
        end
    end
    AST_TEST_AT_ACK: assert property ($changed(test_mode_o) |->
        scl_i && sda_oe_o)
        else $error("test mode moved outside the ack clock high");
    AST_TEST_FULL: assert property (test_mode_o && $past(test_mode_o)
        |-> drive_level_increment_o == {28{5'h10}})
        else $error("test mode without full drive");
    AST_RANGE: assert property (!over_range)
        else $error("drive above sixteen steps");
    AST_SEG_OFF: assert property (!$past(seg_on_i[0])
        && !$past(test_mode_o) |-> drive_level_increment_o[0] == 5'h00)
        else $error("unlit segment driven");
    AST_FLAG_CLR: assert property ($fell(change_flag_o) |->
        scl_i && !sda_oe_o)
        else $error("flag cleared off the ack clock");
    AST_FLAG_SET: assert property ($rose(change_flag_o)
        |-> port_in_i != $past(port_in_i, 6))
        else $error("flag set without port change");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("sda moved while scl high");
    cover property ($rose(test_mode_o));
    cover property ($fell(change_flag_o));
    cover property ($rose(sda_oe_o));
endmodule // lpm_bank_chk

bind lpm_bank lpm_bank_chk i_chk (.mclk_i, .reset_n_i, .scl_i, .sda_oe_o,
    .port_in_i, .seg_on_i, .drive_level_increment_o, .test_mode_o,
    .change_flag_o);

// ===== testbench/lpm_i2c_host.sv
// i2c bus controller model that drives the bank pins
`timescale 1ns/1ns
module lpm_i2c_host (
    input  wire logic mclk_i,
    input  wire logic sda_w_i,
    output logic      scl_o,
    output logic      sda_o
);
    // bus idles released; the pull-up reads high
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // six mclk a phase keeps clear of the synchroniser delay
    task automatic ph();
        repeat (6) @(posedge mclk_i);
        #1;
    endtask
    // start or repeated start
    task automatic start();
        sda_o = 1'b1;
        ph();
        scl_o = 1'b1;
        ph();
        sda_o = 1'b0;
        ph();
        scl_o = 1'b0;
        ph();
    endtask
    task automatic stop();
        sda_o = 1'b0;
        ph();
        scl_o = 1'b1;
        ph();
        sda_o = 1'b1;
        ph();
    endtask
    // data only changes in the scl low phase
    task automatic xbit(input logic b, output logic r);
        sda_o = b;
        ph();
        scl_o = 1'b1;
        ph();
        r = sda_w_i;
        scl_o = 1'b0;
        ph();
    endtask
    // msb first, then the acknowledge bit a
    task automatic xbyte(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(a, r);
    endtask
endmodule // lpm_i2c_host

// ===== testbench/tb_led_port_mask_and_test_regs.sv
// self-checking bench for the led port mask and test register bank
`timescale 1ns/1ns
`include "lpm_regs.svh"
module tb_led_port_mask_and_test_regs;
    logic             mclk, reset_n, scl, host_sda, sda_w, sda_oe;
    logic             test_mode, flag;
    logic [6:0]       port_in;
    logic [27:0]      seg_on;
    logic [27:0][4:0] drive;
    logic [7:0]       v;
    logic             dut_sda, nak;
    int               failures, compares, cyc;
    // open drain wire with pull-up; the pulled level comes from the pin
    assign sda_w = host_sda & (~sda_oe | dut_sda);
    lpm_i2c_host i_host (.mclk_i(mclk), .sda_w_i(sda_w), .scl_o(scl),
        .sda_o(host_sda));
    lpm_bank i_dut (.mclk_i(mclk), .reset_n_i(reset_n), .scl_i(scl),
        .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(sda_oe),
        .port_in_i(port_in),
        .seg_on_i(seg_on), .drive_level_increment_o(drive),
        .test_mode_o(test_mode), .change_flag_o(flag));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // write one register; all three bytes must be acked
    task automatic reg_wr(input logic [7:0] o, input logic [7:0] d);
        logic [7:0] q;
        logic       a0, a1, a2;
        i_host.start();
        i_host.xbyte({`LPM_DEV_ADDR, 1'b0}, 1'b1, q, a0);
        i_host.xbyte(o, 1'b1, q, a1);
        i_host.xbyte(d, 1'b1, q, a2);
        i_host.stop();
        chk({5'h00, a0, a1, a2}, 8'h00); // all bytes acknowledged
    endtask
    // set pointer, repeated start, read one byte and nack it
    task automatic reg_rd(input logic [7:0] o, output logic [7:0] d);
        logic a;
        i_host.start();
        i_host.xbyte({`LPM_DEV_ADDR, 1'b0}, 1'b1, d, a);
        i_host.xbyte(o, 1'b1, d, a);
        i_host.start();
        i_host.xbyte({`LPM_DEV_ADDR, 1'b1}, 1'b1, d, a);
        i_host.xbyte(8'hff, 1'b1, d, a);
        i_host.stop();
    endtask
    task automatic port_set(input logic [6:0] p);
        port_in = p;
        repeat (10) @(posedge mclk);
        #1;
    endtask
    // hang guard, runs take about 10000 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        {reset_n, port_in, seg_on, failures, compares, cyc} = '0;
        seg_on = '1;
        repeat (8) @(posedge mclk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge mclk);
        reg_rd(`LPM_OFS_MASK, v);
        chk(v, 8'h00); // reset state
        reg_rd(`LPM_OFS_TEST, v);
        chk(v, 8'h00); // reset state
        reg_wr(`LPM_OFS_MASK, 8'h8a);
        reg_rd(`LPM_OFS_MASK, v);
        chk(v, 8'h0a); // bit 7 ignored
        port_set(7'h01);
        chk({7'h00, flag}, 8'h00); // masked port ignored
        port_set(7'h03);
        chk({7'h00, flag}, 8'h01); // masked change flags
        reg_rd(`LPM_OFS_MASK, v);
        chk(v, 8'h8a); // flag in bit 7
        chk({7'h00, flag}, 8'h00); // flag cleared
        reg_rd(`LPM_OFS_MASK, v);
        chk(v, 8'h0a); // clear after read
        reg_rd(8'h30, v);
        chk(v, 8'h00); // unmapped reads zero
        reg_wr(`LPM_OFS_TEST, 8'hfe);
        chk({7'h00, test_mode}, 8'h00); // only bit 0 acts
        reg_wr(`LPM_OFS_TEST, 8'h01);
        chk({7'h00, test_mode}, 8'h01); // test on
        chk({3'h0, drive[9]}, 8'h10); // full drive
        reg_rd(`LPM_OFS_TEST, v);
        chk(v, 8'h01); // test register read back
        reg_wr(`LPM_OFS_TEST, 8'h00);
        reg_wr(`LPM_OFS_CONFIG, 8'h40);
        reg_wr(`LPM_OFS_SEG_FIRST, 8'h5f);
        chk({3'h0, drive[0]}, 8'h10); // low nibble full
        chk({3'h0, drive[1]}, 8'h06); // high nibble six steps
        reg_wr(`LPM_OFS_SEG_LAST, 8'h2c);
        chk({3'h0, drive[26]}, 8'h0d); // last register low nibble
        chk({3'h0, drive[27]}, 8'h03); // last register high nibble
        seg_on[0] = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk({3'h0, drive[0]}, 8'h00); // off
        reg_wr(`LPM_OFS_CONFIG, 8'h00);
        reg_wr(`LPM_OFS_GLOBAL_CUR, 8'h03);
        chk({3'h0, drive[1]}, 8'h04); // global setting used
        // a foreign address must be left unacknowledged
        i_host.start();
        i_host.xbyte({7'h41, 1'b0}, 1'b1, v, nak);
        i_host.stop();
        chk({7'h00, nak}, 8'h01); // foreign address not acked
        test_done();
    end
endmodule // tb_led_port_mask_and_test_regs

// ===== verilog/lpm_bank.sv
// i2c register bank: transition mask, display test and segment currents
`timescale 1ns/1ns
`include "lpm_regs.svh"

// How it works
// - mask write keeps bits 6..0, ignores 7
// - mask read returns flag and mask
// - flag clears after it is read
// - test bit 0 selects display test
// - write lands at acknowledge rising edge
// - each segment off or 1..16 steps
// - config bit picks global or segment current
module lpm_bank #(
    parameter logic [6:0] DEV_ADDR = `LPM_DEV_ADDR
) (
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    input  wire logic [6:0]        port_in_i,
    input  wire logic [27:0]       seg_on_i,
    output logic [27:0][4:0]       drive_level_increment_o,
    output logic                   test_mode_o,
    output logic                   change_flag_o
);
    // ***********************************************************************
    // register read decode
    // ***********************************************************************
    function automatic logic [7:0] rd_reg(input lpm_pkg::lpm_state_s_t s,
                                          input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == `LPM_OFS_GLOBAL_CUR) begin
            v = s.glob;
        end else if (a == `LPM_OFS_CONFIG) begin
            v = s.cfg;
        end else if (a == `LPM_OFS_MASK) begin
            v = {s.flag, s.mask};
        end else if (a == `LPM_OFS_TEST) begin
            v = s.test;
        end else if (a >= `LPM_OFS_SEG_FIRST && a <= `LPM_OFS_SEG_LAST) begin
            v = s.seg[4'(a - `LPM_OFS_SEG_FIRST)];
        end
        return v;
    endfunction

    lpm_pkg::lpm_state_s_t s_q;
    lpm_pkg::lpm_state_s_t s_d;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_seen;
    logic                  stop_seen;
    logic                  flag_set;
    logic                  flag_clr;
    logic [3:0]            nib;

    // ***********************************************************************
    // next state
    // ***********************************************************************
    always_comb begin
        s_d = s_q;
        flag_clr = 1'b0;
        nib = 4'h0;
        // bus and port pins pass two flops before anything looks at them; seg_on_i feeds the drive logic directly
        s_d.scl_m = scl_i;
        s_d.scl_s = s_q.scl_m;
        s_d.scl_p = s_q.scl_s;
        s_d.sda_m = sda_i;
        s_d.sda_s = s_q.sda_m;
        s_d.sda_p = s_q.sda_s;
        s_d.prt_m = port_in_i;
        s_d.prt_s = s_q.prt_m;
        s_d.prt_p = s_q.prt_s;
        scl_rise = s_q.scl_s & ~s_q.scl_p;
        scl_fall = ~s_q.scl_s & s_q.scl_p;
        start_seen = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
        stop_seen = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;

        unique case (s_q.st)
            lpm_pkg::LPM_ST_IDLE: begin
                s_d.sda_oe = 1'b0;
            end
            lpm_pkg::LPM_ST_RX: begin
                if (scl_rise) begin
                    s_d.sh = {s_q.sh[6:0], s_q.sda_s};
                    s_d.cnt = s_q.cnt + 4'h1;
                end else if (scl_fall && s_q.cnt == `LPM_BITS_PER_BYTE) begin
                    s_d.cnt = 4'h0;
                    if (s_q.role != lpm_pkg::LPM_ROLE_ADDR ||
                        s_q.sh[7:1] == DEV_ADDR) begin
                        s_d.st = lpm_pkg::LPM_ST_ACK;
                        s_d.sda_oe = 1'b1;
                        if (s_q.role == lpm_pkg::LPM_ROLE_ADDR) begin
                            s_d.rw = s_q.sh[0];
                        end
                    end else begin
                        // not our address: stay off the bus until next start
                        s_d.st = lpm_pkg::LPM_ST_IDLE;
                    end
                end
            end
            lpm_pkg::LPM_ST_ACK: begin
                if (scl_rise) begin
                    if (s_q.role == lpm_pkg::LPM_ROLE_CMD) begin
                        s_d.ptr = s_q.sh;
                    end else if (s_q.role == lpm_pkg::LPM_ROLE_DATA) begin
                        s_d.ptr = s_q.ptr + 8'h01;
                        if (s_q.ptr == `LPM_OFS_GLOBAL_CUR) begin
                            s_d.glob = s_q.sh;
                        end else if (s_q.ptr == `LPM_OFS_CONFIG) begin
                            s_d.cfg = s_q.sh;
                        end else if (s_q.ptr == `LPM_OFS_MASK) begin
                            s_d.mask = s_q.sh[6:0];
                        end else if (s_q.ptr == `LPM_OFS_TEST) begin
                            s_d.test = s_q.sh;
                        end else if (s_q.ptr >= `LPM_OFS_SEG_FIRST &&
                                     s_q.ptr <= `LPM_OFS_SEG_LAST) begin
                            s_d.seg[4'(s_q.ptr - `LPM_OFS_SEG_FIRST)] = s_q.sh;
                        end
                    end
                end else if (scl_fall) begin
                    if (s_q.role == lpm_pkg::LPM_ROLE_ADDR && s_q.rw) begin
                        // first read byte goes out on this fall
                        s_d.st = lpm_pkg::LPM_ST_TX;
                        s_d.sh = rd_reg(s_q, s_q.ptr);
                        s_d.sda_oe = ~s_d.sh[7];
                    end else begin
                        s_d.st = lpm_pkg::LPM_ST_RX;
                        s_d.sda_oe = 1'b0;
                        if (s_q.role == lpm_pkg::LPM_ROLE_ADDR) begin
                            s_d.role = lpm_pkg::LPM_ROLE_CMD;
                        end else begin
                            s_d.role = lpm_pkg::LPM_ROLE_DATA;
                        end
                    end
                end
            end
            lpm_pkg::LPM_ST_TX: begin
                if (scl_rise) begin
                    s_d.cnt = s_q.cnt + 4'h1;
                end else if (scl_fall) begin
                    if (s_q.cnt == `LPM_BITS_PER_BYTE) begin
                        s_d.cnt = 4'h0;
                        s_d.sda_oe = 1'b0;
                        s_d.st = lpm_pkg::LPM_ST_RACK;
                    end else begin
                        s_d.sh = {s_q.sh[6:0], 1'b0};
                        s_d.sda_oe = ~s_q.sh[6];
                    end
                end
            end
            lpm_pkg::LPM_ST_RACK: begin
                if (scl_rise) begin
                    s_d.acked = ~s_q.sda_s;
                    s_d.ptr = s_q.ptr + 8'h01;
                    flag_clr = (s_q.ptr == `LPM_OFS_MASK);
                end else if (scl_fall) begin
                    if (s_q.acked) begin
                        s_d.st = lpm_pkg::LPM_ST_TX;
                        s_d.sh = rd_reg(s_q, s_q.ptr);
                        s_d.sda_oe = ~s_d.sh[7];
                    end else begin
                        s_d.st = lpm_pkg::LPM_ST_IDLE;
                    end
                end
            end
            default: begin
                s_d.st = lpm_pkg::LPM_ST_IDLE;
                s_d.sda_oe = 1'b0;
            end
        endcase

        // start and stop override any byte in progress
        if (start_seen) begin
            s_d.st = lpm_pkg::LPM_ST_RX;
            s_d.role = lpm_pkg::LPM_ROLE_ADDR;
            s_d.cnt = 4'h0;
            s_d.sda_oe = 1'b0;
        end else if (stop_seen) begin
            s_d.st = lpm_pkg::LPM_ST_IDLE;
            s_d.sda_oe = 1'b0;
        end

        // a change in the clearing cycle still sets the flag
        flag_set = |((s_q.prt_s ^ s_q.prt_p) & s_q.mask);
        s_d.flag = flag_set | (s_q.flag & ~flag_clr);

        // per segment level, registered so the outputs come from flops
        for (int i = 0; i < 28; i++) begin
            if (s_q.cfg[`LPM_CFG_SEG_CUR_BIT]) begin
                nib = i[0] ? s_q.seg[i/2][7:4] : s_q.seg[i/2][3:0];
            end else begin
                nib = s_q.glob[3:0];
            end
            // test lights all at full scale
            if (s_q.test[`LPM_TEST_ON_BIT]) begin
                s_d.drive[i] = `LPM_LEVEL_FULL;
            // off or one of sixteen steps
            end else if (seg_on_i[i]) begin
                s_d.drive[i] = {1'b0, nib} + 5'h01;
            end else begin
                s_d.drive[i] = 5'h00;
            end
        end
    end

    // ***********************************************************************
    // state register
    // ***********************************************************************
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
            s_q.scl_m <= 1'b1;
            s_q.scl_s <= 1'b1;
            s_q.scl_p <= 1'b1;
            s_q.sda_m <= 1'b1;
            s_q.sda_s <= 1'b1;
            s_q.sda_p <= 1'b1;
            s_q.st <= lpm_pkg::LPM_ST_IDLE;
            s_q.role <= lpm_pkg::LPM_ROLE_ADDR;
            s_q.glob <= `LPM_RST_GLOBAL_CUR;
            s_q.cfg <= `LPM_RST_CONFIG;
            s_q.mask <= `LPM_RST_MASK;
            s_q.test <= `LPM_RST_TEST;
            s_q.seg <= {14{`LPM_RST_SEG_CUR}};
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = s_q.sda_oe;
    assign drive_level_increment_o = s_q.drive;
    assign test_mode_o = s_q.test[`LPM_TEST_ON_BIT];
    assign change_flag_o = s_q.flag;

endmodule // lpm_bank

// ===== verilog/lpm_pkg.sv
// types shared by the led port mask and test register bank
package lpm_pkg;
    // bus slave states, one-hot
    typedef enum logic [4:0] {
        LPM_ST_IDLE = 5'h01,
        LPM_ST_RX   = 5'h02,
        LPM_ST_ACK  = 5'h04,
        LPM_ST_TX   = 5'h08,
        LPM_ST_RACK = 5'h10
    } lpm_state_t;

    // which byte of a transfer is being received
    typedef enum logic [1:0] {
        LPM_ROLE_ADDR = 2'h0,
        LPM_ROLE_CMD  = 2'h1,
        LPM_ROLE_DATA = 2'h2
    } lpm_role_t;

    // whole state of the block
    typedef struct packed {
        logic             scl_m;
        logic             scl_s;
        logic             scl_p;
        logic             sda_m;
        logic             sda_s;
        logic             sda_p;
        logic [6:0]       prt_m;
        logic [6:0]       prt_s;
        logic [6:0]       prt_p;
        lpm_state_t       st;
        lpm_role_t        role;
        logic [3:0]       cnt;
        logic             rw;
        logic             acked;
        logic [7:0]       sh;
        logic [7:0]       ptr;
        logic             sda_oe;
        logic [7:0]       glob;
        logic [7:0]       cfg;
        logic [6:0]       mask;
        logic             flag;
        logic [7:0]       test;
        logic [13:0][7:0] seg;
        logic [27:0][4:0] drive;
    } lpm_state_s_t;
endpackage : lpm_pkg

// ===== verilog/lpm_regs.svh
// register offsets, field positions, reset values, drive levels and bus figures
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH
// ***********************************************************************
// register offsets
// ***********************************************************************
`define LPM_OFS_GLOBAL_CUR  8'h02
`define LPM_OFS_CONFIG      8'h04
`define LPM_OFS_MASK        8'h06
`define LPM_OFS_TEST        8'h07
`define LPM_OFS_SEG_FIRST   8'h12
`define LPM_OFS_SEG_LAST    8'h1f
// ***********************************************************************
// field positions
// ***********************************************************************
`define LPM_CFG_SEG_CUR_BIT 6
`define LPM_MASK_FLAG_BIT   7
`define LPM_TEST_ON_BIT     0
// ***********************************************************************
// reset values
// ***********************************************************************
`define LPM_RST_GLOBAL_CUR  8'h00
`define LPM_RST_CONFIG      8'h00
`define LPM_RST_MASK        7'h00
`define LPM_RST_TEST        8'h00
`define LPM_RST_SEG_CUR     8'h00
// ***********************************************************************
// drive levels and bus figures
// ***********************************************************************
`define LPM_LEVEL_FULL      5'h10
`define LPM_BITS_PER_BYTE   4'h8
`define LPM_DEV_ADDR        7'h40
`endif
